/* rtl/timer_oc_pkg.sv */
// Purpose: constants and carriers for the timer output compare unit
// Assumes: 8-bit cpu bus, one 10 MHz clock
// Notes: register offsets are local byte addresses on the peripheral bus
package timer_oc_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [2:0] ADDR_CONTROL = 3'h0;
   localparam logic [2:0] ADDR_STATUS = 3'h1;
   localparam logic [2:0] ADDR_COUNT_UPPER = 3'h2;
   localparam logic [2:0] ADDR_COUNT_LOWER = 3'h3;
   localparam logic [2:0] ADDR_CMP_UPPER = 3'h4;
   localparam logic [2:0] ADDR_CMP_LOWER = 3'h5;
   localparam logic [2:0] ADDR_IRQ_REQUEST = 3'h6;
   localparam logic [2:0] ADDR_IRQ_ENABLE = 3'h7;

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] CMP_RESET = 8'hFF;
   localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam int IRQ_BIT_HIGH = 1;
   localparam int IRQ_BIT_LOW = 0;
   localparam logic [2:0] CLK_SEL_SUB = 3'h7;
   localparam logic [2:0] CLK_SEL_DIV4 = 3'h6;
   localparam logic [2:0] CLK_SEL_DIV16 = 3'h5;
   localparam logic [2:0] CLK_SEL_DIV32 = 3'h4;
   localparam logic [1:0] HCLK_CASCADE = 2'h0;
   localparam logic [1:0] HCLK_DIV32 = 2'h1;
   localparam logic [1:0] HCLK_DIV16 = 2'h2;

   // ----------------------------------------------------------------
   // timing counts
   // ----------------------------------------------------------------
   localparam int SUB_DIVIDE = 4;
   localparam logic [4:0] PRESC_DIV32_END = 5'h1F;
   localparam logic [3:0] PRESC_DIV16_END = 4'hF;
   localparam logic [1:0] PRESC_DIV4_END = 2'h3;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic high_output_level;
      logic width_select_bit;
      logic [1:0] high_clock_select;
      logic low_output_level;
      logic low_clock_select_2;
      logic low_clock_select_1;
      logic low_clock_select_0;
   } timer_control_t;

   typedef struct packed {
      logic high_overflow_flag;
      logic high_match_flag;
      logic high_overflow_irq_enable;
      logic high_clear_on_match;
      logic low_overflow_flag;
      logic low_match_flag;
      logic low_overflow_irq_enable;
      logic low_clear_on_match;
   } timer_status_t;

endpackage : timer_oc_pkg

/* rtl/timer_output_compare_unit.sv */
// Purpose: compare, flag, request and toggle logic of a 16/8-bit timer
// Assumes: bus strobes and pin inputs synchronous to clk
// Notes: the shared staging byte serves counter and compare in 16-bit mode
`timescale 1ns/1ps
`default_nettype none

module timer_output_compare_unit #(
   parameter int SUB_DIV = timer_oc_pkg::SUB_DIVIDE
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // cpu byte bus
   input wire logic [2:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   // count sources
   input wire logic event_count_input,
   input wire logic subclock_tick,
   // pins and requests
   output logic high_toggle_pin,
   output logic low_toggle_pin,
   output logic irq_high,
   output logic irq_low
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   timer_oc_pkg::timer_control_t timer_control_reg;
   timer_oc_pkg::timer_status_t timer_control_status_reg;
   logic [7:0] count_upper_byte;
   logic [7:0] count_lower_byte;
   logic [7:0] compare_value_upper_byte;
   logic [7:0] compare_value_lower_byte;
   logic [7:0] staging;
   logic [1:0] irq_request_reg;
   logic [1:0] irq_enable_reg;
   logic [4:0] presc;
   logic [1:0] sub_cnt;
   logic event_prev;
   logic eq_high_prev;
   logic eq_low_prev;

   // the sub-tick counter is two bits wide, so four is the deepest divide
   if (SUB_DIV < 1 || SUB_DIV > 4) begin : g_bad_sub_div
      $error("SUB_DIV must be 1..4");
   end

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire mode16 = ~timer_control_reg.width_select_bit;
   wire wr_ctrl = bus_wr && bus_addr == timer_oc_pkg::ADDR_CONTROL;
   wire wr_stat = bus_wr && bus_addr == timer_oc_pkg::ADDR_STATUS;
   wire wr_cnt_h = bus_wr && bus_addr == timer_oc_pkg::ADDR_COUNT_UPPER;
   wire wr_cnt_l = bus_wr && bus_addr == timer_oc_pkg::ADDR_COUNT_LOWER;
   wire wr_cmp_h = bus_wr && bus_addr == timer_oc_pkg::ADDR_CMP_UPPER;
   wire wr_cmp_l = bus_wr && bus_addr == timer_oc_pkg::ADDR_CMP_LOWER;
   wire wr_irq = bus_wr && bus_addr == timer_oc_pkg::ADDR_IRQ_REQUEST;
   wire wr_ien = bus_wr && bus_addr == timer_oc_pkg::ADDR_IRQ_ENABLE;
   wire rd_cnt_h = bus_rd && bus_addr == timer_oc_pkg::ADDR_COUNT_UPPER;

   // ----------------------------------------------------------------
   // count enables
   // ----------------------------------------------------------------
   wire [2:0] low_sel = {timer_control_reg.low_clock_select_2, timer_control_reg.low_clock_select_1,
                         timer_control_reg.low_clock_select_0};
   wire tick_div32 = presc == timer_oc_pkg::PRESC_DIV32_END;
   wire tick_div16 = presc[3:0] == timer_oc_pkg::PRESC_DIV16_END;
   wire tick_div4 = presc[1:0] == timer_oc_pkg::PRESC_DIV4_END;
   wire sub_wrap = sub_cnt == 2'(SUB_DIV - 1);
   wire tick_sub = subclock_tick && sub_wrap;
   wire tick_event = event_count_input && !event_prev;
   wire tick_l = (low_sel == timer_oc_pkg::CLK_SEL_SUB) ? tick_sub :
                 (low_sel == timer_oc_pkg::CLK_SEL_DIV4) ? tick_div4 :
                 (low_sel == timer_oc_pkg::CLK_SEL_DIV16) ? tick_div16 :
                 (low_sel == timer_oc_pkg::CLK_SEL_DIV32) ? tick_div32 : tick_event;
   wire low_at_top = count_lower_byte == timer_oc_pkg::BYTE_ALL_ONES;
   wire high_at_top = count_upper_byte == timer_oc_pkg::BYTE_ALL_ONES;
   wire carry_l = tick_l && low_at_top;
   wire tick_h8 = (timer_control_reg.high_clock_select == timer_oc_pkg::HCLK_CASCADE) ? carry_l :
                  (timer_control_reg.high_clock_select == timer_oc_pkg::HCLK_DIV32) ? tick_div32 :
                  (timer_control_reg.high_clock_select == timer_oc_pkg::HCLK_DIV16) ? tick_div16 : tick_div4;
   wire tick_h = mode16 ? carry_l : tick_h8;

   // a write to the counter byte in the same cycle swallows the overflow
   wire ovf_l = !mode16 && carry_l && !wr_cnt_l;
   wire ovf_h = mode16 ? (carry_l && high_at_top && !wr_cnt_l) : (tick_h8 && high_at_top && !wr_cnt_h);

   // ----------------------------------------------------------------
   // compare
   // ----------------------------------------------------------------
   wire eq_high = mode16 ? {count_upper_byte, count_lower_byte} ==
                           {compare_value_upper_byte, compare_value_lower_byte} :
                           count_upper_byte == compare_value_upper_byte;
   wire eq_low = !mode16 && count_lower_byte == compare_value_lower_byte;
   // only the first cycle of equality counts; a compare write kills it
   wire match_h = eq_high && !eq_high_prev && !(mode16 ? wr_cmp_l : wr_cmp_h);
   wire match_l = eq_low && !eq_low_prev && !wr_cmp_l;

   // ----------------------------------------------------------------
   // counter next values
   // ----------------------------------------------------------------
   wire clr_h = match_h && timer_control_status_reg.high_clear_on_match;
   wire clr_l = mode16 ? clr_h : match_l && timer_control_status_reg.low_clear_on_match;
   logic [7:0] next_count_upper;
   logic [7:0] next_count_lower;
   logic [7:0] next_cmp_upper;
   logic [7:0] next_cmp_lower;
   logic [7:0] next_staging;

   always_comb begin
      next_count_upper = count_upper_byte;
      next_count_lower = count_lower_byte;
      if (clr_h) begin
         next_count_upper = timer_oc_pkg::BYTE_ZERO;
      end else if (tick_h) begin
         next_count_upper = count_upper_byte + 8'h01;
      end
      if (clr_l) begin
         next_count_lower = timer_oc_pkg::BYTE_ZERO;
      end else if (tick_l) begin
         next_count_lower = count_lower_byte + 8'h01;
      end
      if (mode16 && wr_cnt_l) begin
         next_count_upper = staging;
         next_count_lower = bus_wdata;
      end else if (!mode16) begin
         if (wr_cnt_h) begin
            next_count_upper = bus_wdata;
         end
         if (wr_cnt_l) begin
            next_count_lower = bus_wdata;
         end
      end
   end

   always_comb begin
      next_cmp_upper = compare_value_upper_byte;
      next_cmp_lower = compare_value_lower_byte;
      next_staging = staging;
      if (mode16) begin
         if (wr_cnt_h || wr_cmp_h) begin
            next_staging = bus_wdata;
         end else if (rd_cnt_h) begin
            next_staging = count_lower_byte;
         end
         if (wr_cmp_l) begin
            next_cmp_upper = staging;
            next_cmp_lower = bus_wdata;
         end
      end else begin
         if (wr_cmp_h) begin
            next_cmp_upper = bus_wdata;
         end
         if (wr_cmp_l) begin
            next_cmp_lower = bus_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // flags: hardware set beats software clear
   // ----------------------------------------------------------------
   timer_oc_pkg::timer_status_t next_status;
   logic [1:0] next_irq_request;
   wire set_req_h = match_h || (ovf_h && timer_control_status_reg.high_overflow_irq_enable);
   wire set_req_l = match_l || (ovf_l && timer_control_status_reg.low_overflow_irq_enable);

   always_comb begin
      next_status = timer_control_status_reg;
      if (wr_stat) begin
         // flags clear on a written 0, controls take the written value
         next_status = timer_oc_pkg::timer_status_t'(bus_wdata & {1'b1, 1'b1, 2'b11, 1'b1, 1'b1, 2'b11});
         next_status.high_overflow_flag = timer_control_status_reg.high_overflow_flag & bus_wdata[7];
         next_status.high_match_flag = timer_control_status_reg.high_match_flag & bus_wdata[6];
         next_status.low_overflow_flag = timer_control_status_reg.low_overflow_flag & bus_wdata[3];
         next_status.low_match_flag = timer_control_status_reg.low_match_flag & bus_wdata[2];
      end
      if (ovf_h) begin
         next_status.high_overflow_flag = 1'b1;
      end
      if (match_h) begin
         next_status.high_match_flag = 1'b1;
      end
      if (ovf_l) begin
         next_status.low_overflow_flag = 1'b1;
      end
      if (match_l) begin
         next_status.low_match_flag = 1'b1;
      end
      next_irq_request = irq_request_reg;
      if (wr_irq) begin
         next_irq_request = irq_request_reg & ~bus_wdata[1:0];
      end
      if (set_req_h) begin
         next_irq_request[timer_oc_pkg::IRQ_BIT_HIGH] = 1'b1;
      end
      if (set_req_l) begin
         next_irq_request[timer_oc_pkg::IRQ_BIT_LOW] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   wire [7:0] read_mux =
      (bus_addr == timer_oc_pkg::ADDR_STATUS) ? timer_control_status_reg :
      (bus_addr == timer_oc_pkg::ADDR_COUNT_UPPER) ? count_upper_byte :
      (bus_addr == timer_oc_pkg::ADDR_COUNT_LOWER) ? (mode16 ? staging : count_lower_byte) :
      (bus_addr == timer_oc_pkg::ADDR_CMP_UPPER) ? compare_value_upper_byte :
      (bus_addr == timer_oc_pkg::ADDR_CMP_LOWER) ? compare_value_lower_byte :
      (bus_addr == timer_oc_pkg::ADDR_IRQ_REQUEST) ? {6'h00, irq_request_reg} :
      (bus_addr == timer_oc_pkg::ADDR_IRQ_ENABLE) ? {6'h00, irq_enable_reg} : 8'h00;

   assign irq_high = irq_request_reg[timer_oc_pkg::IRQ_BIT_HIGH] && irq_enable_reg[timer_oc_pkg::IRQ_BIT_HIGH];
   assign irq_low = irq_request_reg[timer_oc_pkg::IRQ_BIT_LOW] && irq_enable_reg[timer_oc_pkg::IRQ_BIT_LOW];

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         timer_control_reg <= timer_oc_pkg::timer_control_t'(timer_oc_pkg::CONTROL_RESET);
         timer_control_status_reg <= timer_oc_pkg::timer_status_t'(timer_oc_pkg::STATUS_RESET);
         count_upper_byte <= timer_oc_pkg::COUNT_RESET;
         count_lower_byte <= timer_oc_pkg::COUNT_RESET;
         compare_value_upper_byte <= timer_oc_pkg::CMP_RESET;
         compare_value_lower_byte <= timer_oc_pkg::CMP_RESET;
         staging <= timer_oc_pkg::BYTE_ZERO;
         irq_request_reg <= 2'h0;
         irq_enable_reg <= 2'h0;
         bus_rdata <= 8'h00;
      end else begin
         if (wr_ctrl) begin
            timer_control_reg <= timer_oc_pkg::timer_control_t'(bus_wdata);
         end
         timer_control_status_reg <= next_status;
         count_upper_byte <= next_count_upper;
         count_lower_byte <= next_count_lower;
         compare_value_upper_byte <= next_cmp_upper;
         compare_value_lower_byte <= next_cmp_lower;
         staging <= next_staging;
         irq_request_reg <= next_irq_request;
         if (wr_ien) begin
            irq_enable_reg <= bus_wdata[1:0];
         end
         if (bus_rd) begin
            bus_rdata <= read_mux;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         presc <= 5'h00;
         sub_cnt <= 2'h0;
         event_prev <= 1'b0;
         eq_high_prev <= 1'b0;
         eq_low_prev <= 1'b0;
      end else begin
         presc <= presc + 5'h01;
         if (subclock_tick) begin
            sub_cnt <= sub_wrap ? 2'h0 : sub_cnt + 2'h1;
         end
         event_prev <= event_count_input;
         eq_high_prev <= eq_high;
         eq_low_prev <= eq_low;
      end
   end

   // ----------------------------------------------------------------
   // toggle pins: a control write presets the level and beats a match
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         high_toggle_pin <= 1'b0;
         low_toggle_pin <= 1'b0;
      end else if (wr_ctrl) begin
         high_toggle_pin <= bus_wdata[7];
         low_toggle_pin <= bus_wdata[3];
      end else begin
         if (match_h) begin
            high_toggle_pin <= !high_toggle_pin;
         end
         if (match_l) begin
            low_toggle_pin <= !low_toggle_pin;
         end
      end
   end

endmodule : timer_output_compare_unit
`default_nettype wire

/* tb/timer_output_compare_unit_props.sv */
// Purpose: port-level checks of the timer output compare unit
// Assumes: one clock, srst synchronous and active high
// Notes: flags are internal, so pins and requests are tied to bus writes
`timescale 1ns/1ps
`default_nettype none
module timer_oc_props #(
   parameter int SUB_DIV = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // cpu byte bus
   input wire logic [2:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   // count sources
   input wire logic event_count_input,
   input wire logic subclock_tick,
   // pins and requests
   input wire logic high_toggle_pin,
   input wire logic low_toggle_pin,
   input wire logic irq_high,
   input wire logic irq_low
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   wire logic wr_ctrl = bus_wr && bus_addr == timer_oc_pkg::ADDR_CONTROL;
   wire logic wr_en = bus_wr && bus_addr == timer_oc_pkg::ADDR_IRQ_ENABLE;

   AST_RESET_IDLE: assert property ($fell(srst) |-> !high_toggle_pin && !low_toggle_pin
      && !irq_high && !irq_low && bus_rdata == 8'h00) else $error("outputs not idle after reset");
   AST_RDATA_HOLDS: assert property (!bus_rd |=> $stable(bus_rdata))
      else $error("read data moved without a read");
   AST_CONTROL_WRITE_ONLY: assert property (bus_rd && bus_addr == timer_oc_pkg::ADDR_CONTROL
      |=> bus_rdata == 8'h00) else $error("control register read not zero");
   AST_HIGH_LEVEL_PRESET: assert property (wr_ctrl |=> high_toggle_pin == $past(bus_wdata[7]))
      else $error("high pin not preset by control write");
   AST_LOW_LEVEL_PRESET: assert property (wr_ctrl |=> low_toggle_pin == $past(bus_wdata[3]))
      else $error("low pin not preset by control write");
   AST_HIGH_IRQ_GATED: assert property (wr_en && !bus_wdata[1] |=> !irq_high)
      else $error("high irq with enable off");
   AST_LOW_IRQ_GATED: assert property (wr_en && !bus_wdata[0] |=> !irq_low)
      else $error("low irq with enable off");
   AST_HIGH_IRQ_HOLDS: assert property (irq_high && !bus_wr |=> irq_high)
      else $error("high irq dropped without a write");
   AST_LOW_IRQ_HOLDS: assert property (irq_low && !bus_wr |=> irq_low)
      else $error("low irq dropped without a write");

   cover property ($rose(irq_high));
   cover property ($rose(irq_low));
   cover property (wr_ctrl ##1 high_toggle_pin);
endmodule : timer_oc_props

bind timer_output_compare_unit timer_oc_props #(.SUB_DIV(SUB_DIV)) props (.clk(clk), .srst(srst),
   .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
   .event_count_input(event_count_input), .subclock_tick(subclock_tick), .high_toggle_pin(high_toggle_pin),
   .low_toggle_pin(low_toggle_pin), .irq_high(irq_high), .irq_low(irq_low));
`default_nettype wire

/* tb/cpu_bus_model.sv */
// Purpose: cpu side of the peripheral byte bus
// Assumes: one-cycle strobes, read data valid the cycle after the read
// Notes: released lines show the inverse so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
   // clock
   input wire logic clk,
   // cpu byte bus
   output logic [2:0] bus_addr,
   output logic bus_wr,
   output logic bus_rd,
   output logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata
);
   initial begin
      bus_addr = 3'h0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_wdata = 8'h00;
   end

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
      bus_addr <= ~a;
      bus_wdata <= ~d;
      #1;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      bus_addr <= ~a;
      @(posedge clk);
      d = bus_rdata;
   endtask : rd

   // upper byte first: it lands in the staging byte, lower write loads both
   task automatic wr16(input logic [2:0] a, input logic [15:0] d);
      wr(a, d[15:8]);
      wr(a + 3'h1, d[7:0]);
   endtask : wr16

   task automatic rd16(input logic [2:0] a, output logic [15:0] d);
      logic [7:0] hi;
      logic [7:0] lo;
      rd(a, hi);
      rd(a + 3'h1, lo);
      d = {hi, lo};
   endtask : rd16
endmodule : cpu_bus_model
`default_nettype wire

/* tb/timer_output_compare_unit_tb.sv */
// Purpose: self-checking bench of the timer output compare unit
// Assumes: 10 MHz clock, event input as count source unless told otherwise
// Notes: counts kept small so matches come within a few dozen cycles
`timescale 1ns/1ps
`default_nettype none
module timer_output_compare_unit_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic event_count_input = 1'b0;
   logic subclock_tick = 1'b0;
   logic [2:0] bus_addr;
   logic bus_wr;
   logic bus_rd;
   logic [7:0] bus_wdata;
   logic [7:0] bus_rdata;
   logic high_toggle_pin;
   logic low_toggle_pin;
   logic irq_high;
   logic irq_low;
   logic [7:0] d;
   logic [15:0] w;
   int n_fail = 0;
   int num_checks = 0;
   int cycles = 0;

   always #50 clk = ~clk;

   cpu_bus_model cpu (.clk(clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

   timer_output_compare_unit #(.SUB_DIV(4)) dut (.clk(clk), .srst(srst), .bus_addr(bus_addr),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .event_count_input(event_count_input), .subclock_tick(subclock_tick),
      .high_toggle_pin(high_toggle_pin), .low_toggle_pin(low_toggle_pin),
      .irq_high(irq_high), .irq_low(irq_low));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // four idle cycles cover edge detect, count and match latency
   task automatic pulse(input int n, input bit sub);
      repeat (n) begin
         @(posedge clk);
         if (sub) subclock_tick <= 1'b1;
         else event_count_input <= 1'b1;
         @(posedge clk);
         subclock_tick <= 1'b0;
         event_count_input <= 1'b0;
      end
      repeat (4) @(posedge clk);
      #1;
   endtask : pulse

   task automatic end_of_test;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test

   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         end_of_test();
      end
   end

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      cpu.rd(timer_oc_pkg::ADDR_CMP_UPPER, d); chk(d, 8'hFF);
      cpu.rd(timer_oc_pkg::ADDR_CMP_LOWER, d); chk(d, 8'hFF);
      cpu.rd16(timer_oc_pkg::ADDR_COUNT_UPPER, w); chk(w, 16'h0000);
      cpu.rd(timer_oc_pkg::ADDR_STATUS, d); chk(d, 8'h00);
      cpu.rd(timer_oc_pkg::ADDR_CONTROL, d); chk(d, 8'h00);
      $display("test reset done");
   endtask : t_reset

   task automatic t_match16;
      cpu.wr16(timer_oc_pkg::ADDR_CMP_UPPER, 16'h0010);
      cpu.wr(timer_oc_pkg::ADDR_STATUS, 8'h10);
      cpu.wr(timer_oc_pkg::ADDR_IRQ_ENABLE, 8'h02);
      pulse(15, 1'b0); chk({irq_high, high_toggle_pin}, 2'b00);
      pulse(1, 1'b0); chk({irq_high, high_toggle_pin}, 2'b11);
      cpu.rd(timer_oc_pkg::ADDR_STATUS, d); chk(d, 8'h50);
      cpu.rd16(timer_oc_pkg::ADDR_COUNT_UPPER, w); chk(w, 16'h0000);
      cpu.wr(timer_oc_pkg::ADDR_IRQ_REQUEST, 8'h02); chk(irq_high, 1'b0);
      $display("test match16 done");
   endtask : t_match16

   task automatic t_ovf16;
      cpu.wr(timer_oc_pkg::ADDR_STATUS, 8'h20);
      cpu.wr16(timer_oc_pkg::ADDR_CMP_UPPER, 16'h8000);
      cpu.wr16(timer_oc_pkg::ADDR_COUNT_UPPER, 16'hFFFF);
      pulse(1, 1'b0); chk(irq_high, 1'b1);
      cpu.rd(timer_oc_pkg::ADDR_STATUS, d); chk(d, 8'hA0);
      cpu.wr(timer_oc_pkg::ADDR_IRQ_ENABLE, 8'h00); chk(irq_high, 1'b0);
      cpu.wr(timer_oc_pkg::ADDR_IRQ_REQUEST, 8'h02);
      $display("test ovf16 done");
   endtask : t_ovf16

   task automatic t_mode8;
      // halves must differ from the idle count, or the mode switch itself matches
      cpu.wr16(timer_oc_pkg::ADDR_CMP_UPPER, 16'h0204);
      cpu.wr(timer_oc_pkg::ADDR_CONTROL, 8'h48); chk({high_toggle_pin, low_toggle_pin}, 2'b01);
      cpu.wr(timer_oc_pkg::ADDR_CMP_LOWER, 8'h03);
      cpu.wr(timer_oc_pkg::ADDR_CMP_UPPER, 8'h01);
      cpu.rd(timer_oc_pkg::ADDR_CMP_UPPER, d); chk(d, 8'h01);
      cpu.rd(timer_oc_pkg::ADDR_CMP_LOWER, d); chk(d, 8'h03);
      cpu.wr(timer_oc_pkg::ADDR_STATUS, 8'h00);
      cpu.wr(timer_oc_pkg::ADDR_IRQ_ENABLE, 8'h01);
      pulse(2, 1'b0); chk(irq_low, 1'b0);
      pulse(1, 1'b0); chk({irq_low, low_toggle_pin, irq_high}, 3'b100);
      cpu.rd(timer_oc_pkg::ADDR_STATUS, d); chk(d, 8'h04);
      cpu.wr(timer_oc_pkg::ADDR_IRQ_REQUEST, 8'h01); chk(irq_low, 1'b0);
      cpu.wr(timer_oc_pkg::ADDR_STATUS, 8'h02);
      cpu.wr(timer_oc_pkg::ADDR_COUNT_LOWER, 8'hFF);
      pulse(1, 1'b0); chk({irq_low, high_toggle_pin}, 2'b11);
      cpu.rd(timer_oc_pkg::ADDR_STATUS, d); chk(d, 8'h4A);
      $display("test mode8 done");
   endtask : t_mode8

   task automatic t_subclock;
      cpu.wr(timer_oc_pkg::ADDR_CONTROL, 8'h07);
      cpu.wr16(timer_oc_pkg::ADDR_COUNT_UPPER, 16'h0000);
      pulse(8, 1'b1);
      cpu.rd16(timer_oc_pkg::ADDR_COUNT_UPPER, w); chk(w, 16'h0002);
      $display("test subclock done");
   endtask : t_subclock

   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_match16();
      t_ovf16();
      t_mode8();
      t_subclock();
      end_of_test();
   end
endmodule : timer_output_compare_unit_tb
`default_nettype wire
